// ---- design/pmsr_pkg.sv ----
// Constants, types and the state record of the protection mask and status register bank.
// Assumes one 25 MHz clock and a synchronous, active-high reset shared by every module.
//
// Overview of operation
// - Register 0x06 holds five interrupt masks at bits 7,6,2,1,0; one masks, reset one.
// - Register 0x07 masks input overcurrent (bit 7) and wireless reverse overcurrent (bit 6).
// - Register 0x08 bit 4 follows output voltage above its insertion threshold, live.
// - Register 0x08 bit 3 follows input bus below its low-voltage error threshold.
// - Register 0x08 bit 2 follows wireless input above its insertion threshold.
// - Register 0x08 bit 1 follows switching; only one switching_start_event pulse when switching starts.
// - Register 0x08 bit 0 follows input bus above its insertion threshold.
// - Register 0x09 bit 7 follows input bus above the input overvoltage limit.
// - Register 0x09 bit 6 follows output above the output overvoltage limit.
// - Register 0x09 bit 3 follows input bus current above the overcurrent limit.
// - Register 0x09 bit 2 follows reverse current toward wireless input above its limit.
// - Register 0x09 bit 1 follows die temperature above the over-temperature limit.
// - Register 0x09 bit 0 shows watchdog reset pending; reset follows 32 ms later.
// - Register 0x0A bits 2:0 pick output limit 7 V to 14 V, reset 010.
// - Register 0x0B bits 5:0 pick input limit 7.25 V plus code times 250 mV.
// - Input limit code resets to 000111; host keeps codes at or below 111011.
// - Latched flags set on events, interrupt unless masked, clear when read.

package pmsr_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] REG_FLAG_A = 8'h02;
   localparam logic [7:0] REG_FLAG_B = 8'h03;
   localparam logic [7:0] REG_MASK_A = 8'h06;
   localparam logic [7:0] REG_MASK_B = 8'h07;
   localparam logic [7:0] REG_STAT_A = 8'h08;
   localparam logic [7:0] REG_STAT_B = 8'h09;
   localparam logic [7:0] REG_OVP_OUT = 8'h0a;
   localparam logic [7:0] REG_OVP_IN = 8'h0b;
   localparam logic [7:0] REG_OCP = 8'h0c;

   // ***************************************************************
   // Reset values and reserved patterns
   // ***************************************************************
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] MASK_A_RSV = 8'h38;
   localparam logic [7:0] MASK_B_RSV = 8'h3f;
   localparam logic [2:0] OVP_OUT_RST = 3'h2;
   localparam logic [5:0] OVP_IN_RST = 6'h07;
   localparam logic [7:0] OCP_RST = 8'h82;

   // ***************************************************************
   // Flag bit positions
   // ***************************************************************
   localparam int FA_IN_OVP = 7;
   localparam int FA_OUT_OVP = 6;
   localparam int FA_OT_REL = 2;
   localparam int FA_OT = 1;
   localparam int FA_WDT = 0;
   localparam int FB_IN_OCP = 7;
   localparam int FB_WL_OCP = 6;

   // ***************************************************************
   // Synchronised input vector layout
   // ***************************************************************
   localparam int LIVE_W = 11;
   localparam int SYNC_W = 13;
   localparam int IX_IN_PRES = 0;
   localparam int IX_SWITCH = 1;
   localparam int IX_WL_PRES = 2;
   localparam int IX_IN_LOW = 3;
   localparam int IX_OUT_PRES = 4;
   localparam int IX_OT = 5;
   localparam int IX_WL_OCP = 6;
   localparam int IX_IN_OCP = 7;
   localparam int IX_OUT_OVP = 8;
   localparam int IX_IN_OVP = 9;
   localparam int IX_WDT = 10;
   localparam int IX_SCL = 11;
   localparam int IX_SDA = 12;
   localparam logic [SYNC_W-1:0] SYNC_RST = 13'h1800;

   // ***************************************************************
   // Serial interface and timing
   // ***************************************************************
   localparam logic [3:0] I2C_BITS = 4'h8;
   localparam int CLK_KHZ = 25000;
   localparam int WDT_GRACE_MS = 32;
   localparam int WDT_GRACE_CYC = WDT_GRACE_MS * CLK_KHZ;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WDAT, ST_WACK, ST_RDAT, ST_RACK
   } pmsr_i2c_t;

   typedef struct packed {
      pmsr_i2c_t st;
      logic [3:0] bits;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic scl_d;
      logic sda_d;
      logic sda_oe;
      logic [7:0] mask_a;
      logic [7:0] mask_b;
      logic [7:0] flag_a;
      logic [7:0] flag_b;
      logic [2:0] ovp_out;
      logic [5:0] ovp_in;
      logic [7:0] ocp;
      logic [LIVE_W-1:0] live_d;
      logic irq_oe;
      logic zero;
      logic sw_start;
      logic [19:0] wdt_cnt;
      logic wdt_rst;
   } pmsr_state_t;

endpackage

// ---- design/pmsr_sync.sv ----
// Three-stage input synchroniser with agreement filter for pins and comparator levels.
// Assumes the inputs are asynchronous to mclk and change slowly against it.

`timescale 1ns/1ps

module pmsr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Raw and filtered levels
   input wire logic [W-1:0] raw,
   output logic [W-1:0] stable
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pmsr_sync_t;

   pmsr_sync_t r;
   pmsr_sync_t n;
   logic [W-1:0] filt;

   // A level is taken only once the second and third stages agree.
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign filt[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
   end

   always_comb begin
      n = r;
      n.s1 = raw;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.q = filt;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
      end else if (ce) begin
         r <= n;
      end
   end

   assign stable = r.q;

endmodule

// ---- design/pmsr_regs.sv ----
// Protection mask, status and threshold registers with event flags and a serial target.
// Assumes comparator levels arrive asynchronously and the serial bus idles high.

`timescale 1ns/1ps

module pmsr_regs
   import pmsr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h22,
   parameter int unsigned GRACE_CYCLES = WDT_GRACE_CYC
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Interrupt pin, open drain, active low
   output logic irq_n_out,
   output logic irq_n_oe,
   // Comparator and converter levels
   input wire logic input_present,
   input wire logic converter_switching,
   input wire logic wireless_input_present,
   input wire logic input_undervoltage_error,
   input wire logic output_present,
   input wire logic die_overtemp,
   input wire logic wireless_reverse_overcurrent,
   input wire logic input_overcurrent,
   input wire logic output_overvoltage,
   input wire logic input_overvoltage,
   input wire logic watchdog_pending_bit,
   // Threshold codes to the analog side
   output logic [2:0] output_overvoltage_code,
   output logic [5:0] input_overvoltage_code,
   output logic [7:0] overcurrent_limit_code,
   // Events to the rest of the device
   output logic switching_start_event,
   output logic watchdog_reset_event
);

   // ***************************************************************
   // State and constants
   // ***************************************************************
   // Twenty bits hold the full 32 ms grace at 25 MHz; a grace of 42 ms or more would wrap.
   localparam logic [19:0] GRACE_LAST = 20'(GRACE_CYCLES);
   localparam pmsr_state_t ST_RST = '{
      st: ST_IDLE,
      bits: 4'h0,
      sh: 8'h00,
      ptr: 8'h00,
      rw: 1'b0,
      scl_d: 1'b1,
      sda_d: 1'b1,
      sda_oe: 1'b0,
      mask_a: MASK_RST,
      mask_b: MASK_RST,
      flag_a: 8'h00,
      flag_b: 8'h00,
      ovp_out: OVP_OUT_RST,
      ovp_in: OVP_IN_RST,
      ocp: OCP_RST,
      live_d: '0,
      irq_oe: 1'b0,
      zero: 1'b0,
      sw_start: 1'b0,
      wdt_cnt: 20'h00000,
      wdt_rst: 1'b0
   };

   pmsr_state_t r;
   pmsr_state_t next_r;
   logic [SYNC_W-1:0] sy;
   logic [LIVE_W-1:0] live;
   logic [LIVE_W-1:0] rise;
   logic [LIVE_W-1:0] fall;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic load;
   logic [7:0] rd;
   logic [7:0] ev_a;
   logic [7:0] ev_b;
   logic [7:0] clr_a;
   logic [7:0] clr_b;

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   // Serial lines share the level filter, so START and STOP stay ordered against SCL.
   pmsr_sync #(
      .W(SYNC_W),
      .RST_VAL(SYNC_RST)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .raw({sda_in,
            scl_in,
            watchdog_pending_bit,
            input_overvoltage,
            output_overvoltage,
            input_overcurrent,
            wireless_reverse_overcurrent,
            die_overtemp,
            output_present,
            input_undervoltage_error,
            wireless_input_present,
            converter_switching,
            input_present}),
      .stable(sy)
   );

   // ***************************************************************
   // Register read decode
   // ***************************************************************
   // Status bits are live levels; reserved bits read as their fixed values.
   function automatic logic [7:0] read_reg(input logic [7:0] addr, input pmsr_state_t s);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         REG_FLAG_A: v = s.flag_a;
         REG_FLAG_B: v = s.flag_b;
         REG_MASK_A: v = s.mask_a;
         REG_MASK_B: v = s.mask_b;
         // Bits 4..0 are output, undervoltage, wireless, switching and input levels.
         REG_STAT_A: v = {3'h0, s.live_d[IX_OUT_PRES:IX_IN_PRES]};
         REG_STAT_B: begin
            v = {s.live_d[IX_IN_OVP],
                 s.live_d[IX_OUT_OVP], 2'h0,
                 s.live_d[IX_IN_OCP],
                 s.live_d[IX_WL_OCP],
                 s.live_d[IX_OT],
                 s.live_d[IX_WDT]};
         end
         REG_OVP_OUT: v = {5'h00, s.ovp_out};
         REG_OVP_IN: v = {2'h0, s.ovp_in};
         REG_OCP: v = s.ocp;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      next_r = r;
      live = sy[LIVE_W-1:0];
      scl = sy[IX_SCL];
      sda = sy[IX_SDA];
      rise = live & ~r.live_d;
      fall = ~live & r.live_d;
      scl_rise = scl & ~r.scl_d;
      scl_fall = ~scl & r.scl_d;
      start_c = scl & r.scl_d & r.sda_d & ~sda;
      stop_c = scl & r.scl_d & ~r.sda_d & sda;
      load = 1'b0;
      rd = 8'h00;
      clr_a = 8'h00;
      clr_b = 8'h00;
      next_r.scl_d = scl;
      next_r.sda_d = sda;
      next_r.live_d = live;
      next_r.zero = 1'b0;

      // Edge of switching gives one event, however long switching lasts.
      next_r.sw_start = rise[IX_SWITCH];

      // ***************************************************************
      // Watchdog grace timer
      // ***************************************************************
      // Grace timer: counts while a watchdog reset is pending, fires once.
      next_r.wdt_rst = 1'b0;
      if (!live[IX_WDT]) begin
         next_r.wdt_cnt = 20'h00000;
      end else if (r.wdt_cnt != GRACE_LAST) begin
         next_r.wdt_cnt = r.wdt_cnt + 20'h00001;
         next_r.wdt_rst = (r.wdt_cnt == GRACE_LAST - 20'h00001);
      end

      // ***************************************************************
      // Serial target
      // ***************************************************************
      // Serial target: start and stop win over any bit in progress.
      if (start_c) begin
         next_r.st = ST_ADDR;
         next_r.bits = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop_c) begin
         next_r.st = ST_IDLE;
         next_r.sda_oe = 1'b0;
      end else begin
         unique case (r.st)
            ST_IDLE: begin
               next_r.sda_oe = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDAT: begin
               if (scl_rise) begin
                  next_r.sh = {r.sh[6:0], sda};
                  next_r.bits = r.bits + 4'h1;
               end else if (scl_fall && r.bits == I2C_BITS) begin
                  next_r.bits = 4'h0;
                  next_r.sda_oe = 1'b1;
                  if (r.st == ST_ADDR) begin
                     next_r.rw = r.sh[0];
                     next_r.st = ST_AACK;
                     if (r.sh[7:1] != DEV_ADDR) begin
                        next_r.sda_oe = 1'b0;
                        next_r.st = ST_IDLE;
                     end
                  end else if (r.st == ST_PTR) begin
                     next_r.ptr = r.sh;
                     next_r.st = ST_PACK;
                  end else begin
                     next_r.ptr = r.ptr + 8'h01;
                     next_r.st = ST_WACK;
                     case (r.ptr)
                        REG_MASK_A: next_r.mask_a = r.sh | MASK_A_RSV;
                        REG_MASK_B: next_r.mask_b = r.sh | MASK_B_RSV;
                        REG_OVP_OUT: next_r.ovp_out = r.sh[2:0];
                        REG_OVP_IN: next_r.ovp_in = r.sh[5:0];
                        REG_OCP: next_r.ocp = r.sh;
                        default: next_r.ocp = r.ocp;
                     endcase
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.bits = 4'h0;
                  next_r.st = ST_PTR;
                  if (r.rw) begin
                     load = 1'b1;
                  end
               end
            end
            ST_PACK, ST_WACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.bits = 4'h0;
                  next_r.st = ST_WDAT;
               end
            end
            ST_RDAT: begin
               if (scl_fall) begin
                  next_r.bits = r.bits + 4'h1;
                  if (r.bits == I2C_BITS - 4'h1) begin
                     next_r.sda_oe = 1'b0;
                     next_r.st = ST_RACK;
                  end else begin
                     next_r.sh = {r.sh[6:0], 1'b0};
                     next_r.sda_oe = ~r.sh[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise && sda) begin
                  next_r.st = ST_IDLE;
               end else if (scl_fall) begin
                  load = 1'b1;
               end
            end
            // An illegal code drops to idle, so the target waits for the next START.
            default: begin
               next_r.st = ST_IDLE;
            end
         endcase
      end

      // A byte is loaded for reading; reading a flag register clears it.
      if (load) begin
         rd = read_reg(r.ptr, r);
         next_r.sh = rd;
         next_r.sda_oe = ~rd[7];
         next_r.bits = 4'h0;
         next_r.st = ST_RDAT;
         next_r.ptr = r.ptr + 8'h01;
         clr_a = (r.ptr == REG_FLAG_A) ? 8'hff : 8'h00;
         clr_b = (r.ptr == REG_FLAG_B) ? 8'hff : 8'h00;
      end

      // ***************************************************************
      // Event flags and interrupt
      // ***************************************************************
      // Flags latch on edges; a new event in the clearing cycle is kept.
      ev_a = 8'h00;
      ev_a[FA_IN_OVP] = rise[IX_IN_OVP];
      ev_a[FA_OUT_OVP] = rise[IX_OUT_OVP];
      ev_a[FA_OT_REL] = fall[IX_OT];
      ev_a[FA_OT] = rise[IX_OT];
      ev_a[FA_WDT] = rise[IX_WDT];
      ev_b = 8'h00;
      ev_b[FB_IN_OCP] = rise[IX_IN_OCP];
      ev_b[FB_WL_OCP] = rise[IX_WL_OCP];
      next_r.flag_a = (r.flag_a & ~clr_a) | ev_a;
      next_r.flag_b = (r.flag_b & ~clr_b) | ev_b;

      // Any unmasked flag pulls the interrupt line low.
      next_r.irq_oe = |(next_r.flag_a & ~next_r.mask_a) |
                      |(next_r.flag_b & ~next_r.mask_b);

      // Watchdog reset restores thresholds but leaves masks and flags alone.
      if (r.wdt_rst) begin
         next_r.ovp_out = OVP_OUT_RST;
         next_r.ovp_in = OVP_IN_RST;
         next_r.ocp = OCP_RST;
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   // Register reset brings every field, masks included, to its default.
   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= ST_RST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign sda_out = r.zero;
   assign sda_oe = r.sda_oe;
   assign irq_n_out = r.zero;
   assign irq_n_oe = r.irq_oe;
   assign output_overvoltage_code = r.ovp_out;
   assign input_overvoltage_code = r.ovp_in;
   assign overcurrent_limit_code = r.ocp;
   assign switching_start_event = r.sw_start;
   assign watchdog_reset_event = r.wdt_rst;

endmodule

// ---- sim/pmsr_host.sv ----
// Host model that masters the serial bus of the register bank.
// Assumes a pull-up resolves the data line from every open-drain driver.

`timescale 1ns/1ps

module pmsr_host (
   // Clock
   input wire logic mclk,
   // Serial lines
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // *****
   // Bus phases
   // *****
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Every phase lasts five or ten cycles, so the target's input filter sees each level.
   task automatic start();
      sda_low = 1'b0;
      hold(5);
      scl = 1'b1;
      hold(10);
      sda_low = 1'b1;
      hold(10);
      scl = 1'b0;
      hold(5);
   endtask

   task automatic stop();
      sda_low = 1'b1;
      hold(5);
      scl = 1'b1;
      hold(10);
      sda_low = 1'b0;
      hold(10);
   endtask

   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      hold(5);
      scl = 1'b1;
      hold(5);
      r = sda_line;
      hold(5);
      scl = 1'b0;
      hold(5);
   endtask

   task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] r,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(nack, a);
      ack = ~a;
   endtask
endmodule

// ---- sim/pmsr_regs_sva.sv ----
// Port checks for the protection mask and status register bank.
// Assumes one clock domain and a synchronous, active-high register reset.

`timescale 1ns/1ps

module pmsr_regs_sva
   import pmsr_pkg::*;
#(
   parameter int unsigned GRACE_CYCLES = WDT_GRACE_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Open-drain pins
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq_n_out,
   input wire logic irq_n_oe,
   // Levels
   input wire logic converter_switching,
   input wire logic watchdog_pending_bit,
   // Codes and events
   input wire logic [2:0] output_overvoltage_code,
   input wire logic [5:0] input_overvoltage_code,
   input wire logic [7:0] overcurrent_limit_code,
   input wire logic switching_start_event,
   input wire logic watchdog_reset_event
);
   // *****
   // Helper logic
   // *****
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   int unsigned pend_cnt;
   logic fired;
   wire logic dflt = output_overvoltage_code == OVP_OUT_RST &&
      input_overvoltage_code == OVP_IN_RST;

   // The count restarts with each pending episode, since one reset is owed per episode.
   always_ff @(posedge mclk) begin
      if (rst || !watchdog_pending_bit) begin
         pend_cnt <= 0;
         fired <= 1'b0;
      end else begin
         pend_cnt <= pend_cnt + 1;
         fired <= fired | watchdog_reset_event;
      end
   end

   // *****
   // Assertions
   // *****
   a_reset_quiet: assert property ($fell(rst) |-> !irq_n_oe && !sda_oe)
      else $error("pin driven right after reset");
   a_codes_default: assert property ($fell(rst) |-> dflt)
      else $error("threshold codes not at default after reset");
   a_wdt_restore: assert property (watchdog_reset_event |=> dflt &&
      overcurrent_limit_code == OCP_RST)
      else $error("thresholds kept across watchdog reset");
   a_wdt_pulse: assert property (watchdog_reset_event |=> !watchdog_reset_event)
      else $error("watchdog reset longer than one cycle");
   a_wdt_grace: assert property (watchdog_reset_event |-> pend_cnt >= GRACE_CYCLES)
      else $error("watchdog reset before grace time");
   a_wdt_deadline: assert property (pend_cnt == GRACE_CYCLES + 12 |->
      fired || watchdog_reset_event)
      else $error("watchdog reset missing after grace time");
   a_switch_single: assert property (switching_start_event |=>
      (!switching_start_event) [*8])
      else $error("repeated switching event");
   a_switch_cause: assert property (switching_start_event |->
      $past(converter_switching, 2))
      else $error("switching event without switching");
   a_open_drain: assert property (!sda_out && !irq_n_out)
      else $error("open-drain pin drives high");

   cover property (watchdog_reset_event);
   cover property (switching_start_event);
   cover property ($rose(irq_n_oe));
endmodule

bind pmsr_regs pmsr_regs_sva #(.GRACE_CYCLES(GRACE_CYCLES)) pmsr_regs_sva_i (
   .mclk(mclk), .rst(rst), .sda_out(sda_out), .sda_oe(sda_oe),
   .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
   .converter_switching(converter_switching), .watchdog_pending_bit(watchdog_pending_bit),
   .output_overvoltage_code(output_overvoltage_code),
   .input_overvoltage_code(input_overvoltage_code),
   .overcurrent_limit_code(overcurrent_limit_code),
   .switching_start_event(switching_start_event),
   .watchdog_reset_event(watchdog_reset_event));

// ---- sim/pmsr_regs_test.sv ----
// Self-checking bench for the protection mask and status register bank.
// Assumes the host model masters the bus and drives SCL; only the data line is pulled up.

`timescale 1ns/1ps

module pmsr_regs_test;
   import pmsr_pkg::*;
   localparam logic [6:0] DEV = 7'h22;
   localparam int LIMIT = 90000;
   logic mclk;
   logic rst;
   logic [LIVE_W-1:0] lv;
   logic scl, sda_low, sda_oe, irq, sw, ce;
   logic [2:0] oc;
   logic [5:0] ic;
   logic [7:0] lc;
   wire sda = ~(sda_low | sda_oe);
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   int n_sw = 0;

   pmsr_regs #(.DEV_ADDR(DEV), .GRACE_CYCLES(20)) pmsr_regs_i (
      .mclk(mclk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .irq_n_out(), .irq_n_oe(irq),
      .input_present(lv[IX_IN_PRES]), .converter_switching(lv[IX_SWITCH]),
      .wireless_input_present(lv[IX_WL_PRES]), .input_undervoltage_error(lv[IX_IN_LOW]),
      .output_present(lv[IX_OUT_PRES]), .die_overtemp(lv[IX_OT]),
      .wireless_reverse_overcurrent(lv[IX_WL_OCP]), .input_overcurrent(lv[IX_IN_OCP]),
      .output_overvoltage(lv[IX_OUT_OVP]), .input_overvoltage(lv[IX_IN_OVP]),
      .watchdog_pending_bit(lv[IX_WDT]), .output_overvoltage_code(oc),
      .input_overvoltage_code(ic), .overcurrent_limit_code(lc),
      .switching_start_event(sw), .watchdog_reset_event());

   pmsr_host pmsr_host_i (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_low(sda_low));

   // *****
   // Tasks
   // *****
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (sw === 1'b1) n_sw++;
      if (cycles == LIMIT) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k0, k1, k2;
      pmsr_host_i.start();
      pmsr_host_i.xfer({DEV, 1'b0}, 1'b1, r, k0);
      pmsr_host_i.xfer(a, 1'b1, r, k1);
      pmsr_host_i.xfer(d, 1'b1, r, k2);
      pmsr_host_i.stop();
      check({5'h0, k0, k1, k2}, 8'h07);
   endtask

   // Pointer first, then a repeated start, as the target keeps the last pointer.
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r, d;
      logic k0, k1, k2, kn;
      pmsr_host_i.start();
      pmsr_host_i.xfer({DEV, 1'b0}, 1'b1, r, k0);
      pmsr_host_i.xfer(a, 1'b1, r, k1);
      pmsr_host_i.start();
      pmsr_host_i.xfer({DEV, 1'b1}, 1'b1, r, k2);
      pmsr_host_i.xfer(8'hff, 1'b1, d, kn);
      pmsr_host_i.stop();
      check({5'h0, k0, k1, k2}, 8'h07);
      check(d, exp);
   endtask

   // *****
   // Scenarios
   // *****
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      lv = '0;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      expect_reg(REG_MASK_A, 8'hff);
      expect_reg(REG_MASK_B, 8'hff);
      expect_reg(REG_OVP_OUT, 8'h02);
      expect_reg(REG_OVP_IN, 8'h07);
      for (int i = 0; i < LIVE_W; i++) begin
         lv = LIVE_W'(1) << i;
         repeat (10) @(negedge mclk);
         expect_reg(REG_STAT_A, {3'h0, lv[4:0]});
         expect_reg(REG_STAT_B, {lv[IX_IN_OVP], lv[IX_OUT_OVP], 2'h0, lv[IX_IN_OCP],
            lv[IX_WL_OCP], lv[IX_OT], lv[IX_WDT]});
      end
      lv = '0;
      // Switching that comes and goes while the block is frozen must leave no event.
      ce = 1'b0;
      lv[IX_SWITCH] = 1'b1;
      repeat (10) @(negedge mclk);
      lv[IX_SWITCH] = 1'b0;
      repeat (5) @(negedge mclk);
      ce = 1'b1;
      repeat (10) @(negedge mclk);
      check(8'(n_sw), 8'h01);
      reg_write(REG_STAT_A, 8'hff);
      expect_reg(REG_STAT_A, 8'h00);
      expect_reg(REG_STAT_B, 8'h00);
      check({7'h0, irq}, 8'h00);
      reg_write(REG_MASK_A, 8'h00);
      check({7'h0, irq}, 8'h01);
      expect_reg(REG_MASK_A, MASK_A_RSV);
      expect_reg(REG_FLAG_A, 8'hc7);
      check({7'h0, irq}, 8'h00);
      reg_write(REG_MASK_B, 8'h00);
      check({7'h0, irq}, 8'h01);
      expect_reg(REG_MASK_B, MASK_B_RSV);
      expect_reg(REG_FLAG_B, 8'hc0);
      check({7'h0, irq}, 8'h00);
      expect_reg(REG_FLAG_A, 8'h00);
      for (int c = 0; c < 8; c++) begin
         reg_write(REG_OVP_OUT, {5'h1f, 3'(c)});
         reg_write(REG_OVP_IN, {2'h3, 3'(c), 3'h3});
         check({5'h0, oc}, {5'h0, 3'(c)});
         check({2'h0, ic}, {2'h0, 3'(c), 3'h3});
         expect_reg(REG_OVP_OUT, {5'h0, 3'(c)});
         expect_reg(REG_OVP_IN, {2'h0, 3'(c), 3'h3});
      end
      reg_write(8'h20, 8'h5a);
      expect_reg(8'h20, 8'h00);
      reg_write(REG_OCP, 8'h35);
      // The host lets the watchdog run out here on purpose.
      lv[IX_WDT] = 1'b1;
      repeat (40) @(negedge mclk);
      lv[IX_WDT] = 1'b0;
      check({5'h0, oc}, 8'h02);
      check({2'h0, ic}, 8'h07);
      check(lc, OCP_RST);
      expect_reg(REG_MASK_A, MASK_A_RSV);
      rst = 1'b1;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      expect_reg(REG_MASK_A, 8'hff);
      expect_reg(REG_MASK_B, 8'hff);
      give_verdict();
   end
endmodule
